// *** core/port_hmp_pin_function_mux.sv ***
// Pin function priority multiplexer for ports H, M (3:0) and P
`timescale 1ns/1ps
module port_hmp_pin_function_mux
  import hmp_mux_pkg::*;
#(
  parameter int DIV_W = DIV_WIDTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  // LCD frontplane segments 26..19 (port H) and 7..0 (port P)
  input wire logic [PORT_H_WIDTH-1:0] lcdSegEnH,
  input wire logic [PORT_H_WIDTH-1:0] lcdSegOutH,
  input wire logic [PORT_P_WIDTH-1:0] lcdSegEnP,
  input wire logic [PORT_P_WIDTH-1:0] lcdSegOutP,
  // SPI signals routed to port H, indexed by pin 3..0
  input wire pin_drive_s [3:0] spiDrive,
  output logic [3:0] spiIn,
  // SCI1 on port H or M
  input wire logic sciEnH,
  input wire logic sciEnM,
  input wire logic sciTxOut,
  output logic sciRxIn,
  // Bus clock output
  input wire logic busClkOutEn,
  input wire logic [DIV_W-1:0] busClkDiv,
  // Timer channels routed to port M
  input wire pin_drive_s [1:0] timer1Drive,
  input wire pin_drive_s [1:0] timer0Drive,
  output logic [1:0] timer1In,
  output logic [1:0] timer0In,
  // PWM channels 7..0
  input wire pin_drive_s [7:0] pwmDrive,
  output logic [7:0] pwmIn,
  // General-purpose I/O per port
  input wire pad_s [PORT_H_WIDTH-1:0] gpioH,
  input wire pad_s [PORT_M_WIDTH-1:0] gpioM,
  input wire pad_s [PORT_P_WIDTH-1:0] gpioP,
  output logic [PORT_H_WIDTH-1:0] gpioInH,
  output logic [PORT_M_WIDTH-1:0] gpioInM,
  output logic [PORT_P_WIDTH-1:0] gpioInP,
  // Pins
  input wire logic [PORT_H_WIDTH-1:0] portHPinsIn,
  input wire logic [PORT_M_WIDTH-1:0] portMPinsIn,
  input wire logic [PORT_P_WIDTH-1:0] portPPinsIn,
  output logic [PORT_H_WIDTH-1:0] portHPinsOut,
  output logic [PORT_H_WIDTH-1:0] portHPinsOe,
  output logic [PORT_M_WIDTH-1:0] portMPinsOut,
  output logic [PORT_M_WIDTH-1:0] portMPinsOe,
  output logic [PORT_P_WIDTH-1:0] portPPinsOut,
  output logic [PORT_P_WIDTH-1:0] portPPinsOe,
  output pin_src_e [PORT_H_WIDTH-1:0] srcH,
  output pin_src_e [PORT_M_WIDTH-1:0] srcM,
  output pin_src_e [PORT_P_WIDTH-1:0] srcP
);

  // Index bounds of the priority groups on each port
  localparam int DIV_W_MAX = 16;
  localparam int H_LCD_ONLY_LO = 4;
  localparam int SPI_PINS = 4;
  localparam int T0_IDX_RX = 0;
  localparam int T0_IDX_TX = T0_CH_TX - T0_CH_RX;
  localparam int PM_PWM_TOP = PM_PWM_BASE + PORT_M_WIDTH;

  // The pin map is fixed wiring; refuse constants that would tear it apart
  initial begin
    if (DIV_W < 1 || DIV_W > DIV_W_MAX) begin
      $error("DIV_W must lie in 1..16");
    end
    if (PORT_H_WIDTH <= H_LCD_ONLY_LO) begin
      $error("Port H needs LCD-only pins above the shared ones");
    end
    if (PH_SS >= H_LCD_ONLY_LO || SPI_PINS != H_LCD_ONLY_LO) begin
      $error("SPI pins must sit below the LCD-only group of port H");
    end
    if (PH_MISO >= PH_MOSI || PH_MOSI >= PH_SCK || PH_SCK >= PH_SS) begin
      $error("SPI pins of port H are out of order");
    end
    if (PM_T1_HI >= PORT_M_WIDTH || PM_T1_LO > PM_T1_HI) begin
      $error("Timer 1 pins lie outside port M");
    end
    if (PM_PWM_TOP > PORT_P_WIDTH) begin
      $error("PWM channels shared with port M must exist on port P");
    end
    if (T0_IDX_TX < 1 || T0_IDX_TX >= $size(timer0Drive)) begin
      $error("Timer 0 channels must map onto the two routed drives");
    end
    if (PM_TXD == PM_RXD) begin
      $error("SCI1 transmit and receive need separate port M pins");
    end
    if (SEG_P_BASE + PORT_P_WIDTH > SEG_H_BASE) begin
      $error("Port P segments overlap port H segments");
    end
  end

  // Bus clock divider: divide by 2*(div+1), or pass-through when div is 0
  // The counter runs even while the pin is taken by a higher function, so
  // the clock comes back in phase with the divider, not with the enable
  logic [DIV_W-1:0] divCnt_reg;
  logic busClkDiv_reg;
  logic busClkOut;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_reg <= '0;
      busClkDiv_reg <= 1'b0;
    end else if (clkEn) begin
      if (divCnt_reg >= busClkDiv) begin
        divCnt_reg <= '0;
        busClkDiv_reg <= ~busClkDiv_reg;
      end else begin
        divCnt_reg <= divCnt_reg + 1'b1;
      end
    end
  end

  // Undivided rate is the bus clock itself; a glitch-free gate is assumed
  // upstream, so this path is combinational by necessity
  assign busClkOut = (busClkDiv == DIV_W'(DIV_RESET)) ? mclk
                                                      : busClkDiv_reg;

  // Pick the first enabled drive in priority order
  function automatic pad_s pick3(input pin_drive_s a, input pin_drive_s b,
                                 input pin_drive_s c, input pad_s g);
    pad_s r;
    r = g;
    if (a.en) begin
      r = '{out: a.out, oe: a.oe};
    end else if (b.en) begin
      r = '{out: b.out, oe: b.oe};
    end else if (c.en) begin
      r = '{out: c.out, oe: c.oe};
    end
    return r;
  endfunction

  function automatic pin_src_e src3(input logic a, input logic b,
                                    input logic c, input pin_src_e sa,
                                    input pin_src_e sb, input pin_src_e sc);
    pin_src_e r;
    r = SRC_GPIO;
    if (a) begin
      r = sa;
    end else if (b) begin
      r = sb;
    end else if (c) begin
      r = sc;
    end
    return r;
  endfunction

  // Input return of one function: its pin level while it owns the pin,
  // else 0, so a function that lost the pin never sees foreign traffic
  function automatic logic owned(input pin_src_e src, input pin_src_e fn,
                                 input logic level);
    return (src == fn) & level;
  endfunction

  // Drive records of the functions that do not come as structs
  pin_drive_s noDrv;
  pin_drive_s lcdH [PORT_H_WIDTH];
  pin_drive_s lcdP [PORT_P_WIDTH];
  pin_drive_s sciTxDrvH;
  pin_drive_s sciRxDrvH;
  pin_drive_s sciTxDrvM;
  pin_drive_s sciRxDrvM;
  pin_drive_s clkDrv;
  pad_s padH [PORT_H_WIDTH];
  pad_s padM [PORT_M_WIDTH];
  pad_s padP [PORT_P_WIDTH];
  logic sciRxH;
  logic sciRxM;

  always_comb begin
    noDrv = '{en: 1'b0, out: 1'b0, oe: 1'b0};
    for (int i = 0; i < PORT_H_WIDTH; i++) begin
      lcdH[i] = '{en: lcdSegEnH[i], out: lcdSegOutH[i], oe: 1'b1};
    end
    for (int i = 0; i < PORT_P_WIDTH; i++) begin
      lcdP[i] = '{en: lcdSegEnP[i], out: lcdSegOutP[i], oe: 1'b1};
    end
    sciTxDrvH = '{en: sciEnH, out: sciTxOut, oe: 1'b1};
    sciRxDrvH = '{en: sciEnH, out: 1'b0, oe: 1'b0};
    sciTxDrvM = '{en: sciEnM, out: sciTxOut, oe: 1'b1};
    sciRxDrvM = '{en: sciEnM, out: 1'b0, oe: 1'b0};
    clkDrv = '{en: busClkOutEn, out: busClkOut, oe: 1'b1};
  end

  // Port H: LCD-only pins on top, shared SPI/SCI/clock pins below
  always_comb begin
    for (int i = H_LCD_ONLY_LO; i < PORT_H_WIDTH; i++) begin
      padH[i] = pick3(lcdH[i], noDrv, noDrv, gpioH[i]);
      srcH[i] = src3(lcdSegEnH[i], 1'b0, 1'b0, SRC_LCD, SRC_GPIO, SRC_GPIO);
    end
    padH[PH_SS] = pick3(lcdH[PH_SS], spiDrive[PH_SS], noDrv,
                        gpioH[PH_SS]);
    srcH[PH_SS] = src3(lcdSegEnH[PH_SS], spiDrive[PH_SS].en, 1'b0,
                       SRC_LCD, SRC_SPI, SRC_GPIO);
    padH[PH_SCK] = pick3(lcdH[PH_SCK], spiDrive[PH_SCK], clkDrv,
                         gpioH[PH_SCK]);
    srcH[PH_SCK] = src3(lcdSegEnH[PH_SCK], spiDrive[PH_SCK].en,
                        busClkOutEn, SRC_LCD, SRC_SPI, SRC_CLK);
    padH[PH_MOSI] = pick3(lcdH[PH_MOSI], sciTxDrvH, spiDrive[PH_MOSI],
                          gpioH[PH_MOSI]);
    srcH[PH_MOSI] = src3(lcdSegEnH[PH_MOSI], sciEnH, spiDrive[PH_MOSI].en,
                         SRC_LCD, SRC_SCI, SRC_SPI);
    padH[PH_MISO] = pick3(lcdH[PH_MISO], sciRxDrvH, spiDrive[PH_MISO],
                          gpioH[PH_MISO]);
    srcH[PH_MISO] = src3(lcdSegEnH[PH_MISO], sciEnH, spiDrive[PH_MISO].en,
                         SRC_LCD, SRC_SCI, SRC_SPI);
    for (int i = 0; i < PORT_H_WIDTH; i++) begin
      portHPinsOut[i] = padH[i].out;
      portHPinsOe[i] = padH[i].oe;
    end
  end

  // Port M: no LCD here, timers and SCI1 outrank PWM
  always_comb begin
    for (int i = PM_T1_LO; i <= PM_T1_HI; i++) begin
      padM[i] = pick3(timer1Drive[i-PM_T1_LO], pwmDrive[i+PM_PWM_BASE],
                      noDrv, gpioM[i]);
      srcM[i] = src3(timer1Drive[i-PM_T1_LO].en, pwmDrive[i+PM_PWM_BASE].en,
                     1'b0, SRC_TIMER, SRC_PWM, SRC_GPIO);
    end
    padM[PM_TXD] = pick3(sciTxDrvM, timer0Drive[T0_IDX_TX],
                         pwmDrive[PM_TXD+PM_PWM_BASE],
                         gpioM[PM_TXD]);
    srcM[PM_TXD] = src3(sciEnM, timer0Drive[T0_IDX_TX].en,
                        pwmDrive[PM_TXD+PM_PWM_BASE].en,
                        SRC_SCI, SRC_TIMER, SRC_PWM);
    padM[PM_RXD] = pick3(sciRxDrvM, timer0Drive[T0_IDX_RX],
                         pwmDrive[PM_RXD+PM_PWM_BASE],
                         gpioM[PM_RXD]);
    srcM[PM_RXD] = src3(sciEnM, timer0Drive[T0_IDX_RX].en,
                        pwmDrive[PM_RXD+PM_PWM_BASE].en,
                        SRC_SCI, SRC_TIMER, SRC_PWM);
    for (int i = 0; i < PORT_M_WIDTH; i++) begin
      portMPinsOut[i] = padM[i].out;
      portMPinsOe[i] = padM[i].oe;
    end
  end

  // Port P: LCD segments outrank PWM on every pin
  always_comb begin
    for (int i = 0; i < PORT_P_WIDTH; i++) begin
      padP[i] = pick3(lcdP[i], pwmDrive[i], noDrv, gpioP[i]);
      srcP[i] = src3(lcdSegEnP[i], pwmDrive[i].en, 1'b0,
                     SRC_LCD, SRC_PWM, SRC_GPIO);
      portPPinsOut[i] = padP[i].out;
      portPPinsOe[i] = padP[i].oe;
    end
  end

  // Input returns: each function but GPIO sees its pin only while it owns it
  always_comb begin
    for (int i = 0; i < SPI_PINS; i++) begin
      spiIn[i] = owned(srcH[i], SRC_SPI, portHPinsIn[i]);
    end
    // Both SCI1 routes enabled at once ORs the two receive levels;
    // software must keep to one route
    sciRxH = owned(srcH[PH_MISO], SRC_SCI, portHPinsIn[PH_MISO]);
    sciRxM = owned(srcM[PM_RXD], SRC_SCI, portMPinsIn[PM_RXD]);
    sciRxIn = sciRxH | sciRxM;
    timer1In[0] = owned(srcM[PM_T1_LO], SRC_TIMER, portMPinsIn[PM_T1_LO]);
    timer1In[1] = owned(srcM[PM_T1_HI], SRC_TIMER, portMPinsIn[PM_T1_HI]);
    timer0In[T0_IDX_RX] = owned(srcM[PM_RXD], SRC_TIMER,
                                portMPinsIn[PM_RXD]);
    timer0In[T0_IDX_TX] = owned(srcM[PM_TXD], SRC_TIMER,
                                portMPinsIn[PM_TXD]);
    for (int i = 0; i < PORT_P_WIDTH; i++) begin
      pwmIn[i] = owned(srcP[i], SRC_PWM, portPPinsIn[i]);
    end
    // PWM 7..4 appear on both ports; either owned pin reaches the channel
    for (int i = 0; i < PORT_M_WIDTH; i++) begin
      pwmIn[i+PM_PWM_BASE] = pwmIn[i+PM_PWM_BASE]
                           | owned(srcM[i], SRC_PWM, portMPinsIn[i]);
    end
    // GPIO always reads the raw pin, whoever drives it
    gpioInH = portHPinsIn;
    gpioInM = portMPinsIn;
    gpioInP = portPPinsIn;
  end

endmodule

// *** dv/hmp_mux_asserts.sv ***
// Concurrent checks on the pin function multiplexer ports
`timescale 1ns/1ps
module hmp_mux_asserts
  import hmp_mux_pkg::*;
#(
  parameter int DIV_W = DIV_WIDTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [PORT_H_WIDTH-1:0] lcdSegEnH,
  input wire logic [PORT_H_WIDTH-1:0] lcdSegOutH,
  input wire pin_drive_s [3:0] spiDrive,
  input wire logic sciEnH,
  input wire logic sciEnM,
  input wire logic sciTxOut,
  input wire logic busClkOutEn,
  input wire logic [DIV_W-1:0] busClkDiv,
  input wire pin_drive_s [1:0] timer1Drive,
  input wire pin_drive_s [1:0] timer0Drive,
  input wire pin_drive_s [7:0] pwmDrive,
  input wire logic [PORT_H_WIDTH-1:0] portHPinsOut,
  input wire logic [PORT_H_WIDTH-1:0] portHPinsOe,
  input wire logic [PORT_M_WIDTH-1:0] portMPinsOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic ckOn;
  assign ckOn = busClkOutEn && clkEn && busClkDiv == 1 &&
    !lcdSegEnH[2] && !spiDrive[2].en;
  AST_H_LCD: assert property (lcdSegEnH[7] |->
    portHPinsOut[7] == lcdSegOutH[7] && portHPinsOe[7]) else $error("h7");
  AST_H_SS: assert property (!lcdSegEnH[3] && spiDrive[3].en |->
    portHPinsOut[3] == spiDrive[3].out) else $error("h3");
  // Period of four cycles means a level of two cycles
  AST_H_CLK: assert property (ckOn ##1 ckOn && $rose(portHPinsOut[2])
    ##1 ckOn |=> $fell(portHPinsOut[2])) else $error("h2 clock");
  AST_H_TX: assert property (!lcdSegEnH[1] && sciEnH |->
    portHPinsOut[1] == sciTxOut && portHPinsOe[1]) else $error("h1");
  AST_H_RX: assert property (!lcdSegEnH[0] && sciEnH |->
    !portHPinsOe[0]) else $error("h0");
  AST_M_T1: assert property (timer1Drive[1].en |->
    portMPinsOut[3] == timer1Drive[1].out) else $error("m3");
  AST_M_T0: assert property (!sciEnM && timer0Drive[1].en |->
    portMPinsOut[1] == timer0Drive[1].out) else $error("m1");
  AST_M_PWM: assert property (!sciEnM && !timer0Drive[0].en &&
    pwmDrive[4].en |-> portMPinsOut[0] == pwmDrive[4].out) else $error("m0");
endmodule

// *** dv/pad_model.sv ***
// Pin-side model that reflects driven levels and scrambles released pins
`timescale 1ns/1ps
module pad_model #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  output logic [W-1:0] pinIn
);
  logic [W-1:0] floatReg = '0;
  // Released pins flip every cycle so a stale level never passes as driven
  always_ff @(posedge mclk) begin
    floatReg <= ~floatReg;
  end
  assign pinIn = (oe & out) | (~oe & floatReg);
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the port H/M/P pin function multiplexer
`timescale 1ns/1ps
module tb_top;
  import hmp_mux_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn, sciEnH, sciEnM, sciTxOut, sciRxIn, busClkOutEn, prev;
  logic [7:0] lcdSegEnH, lcdSegOutH, lcdSegEnP, lcdSegOutP, busClkDiv;
  logic [7:0] gpioInH, portHPinsIn, portHPinsOut, portHPinsOe;
  logic [7:0] portPPinsIn, portPPinsOut, portPPinsOe;
  logic [3:0] portMPinsIn, portMPinsOut, portMPinsOe, spiIn, gpioInM;
  logic [1:0] timer1In, timer0In;
  logic [7:0] pwmIn, gpioInP;
  pin_drive_s [3:0] spiDrive;
  pin_drive_s [1:0] timer1Drive, timer0Drive;
  pin_drive_s [7:0] pwmDrive;
  pad_s [7:0] gpioH, gpioP;
  pad_s [3:0] gpioM;
  pin_src_e [7:0] srcH, srcP;
  pin_src_e [3:0] srcM;
  int err_total = 0;
  int total_checks = 0;
  int n;
  always #12.5 mclk = ~mclk;
  port_hmp_pin_function_mux uut (.mclk, .rst_b, .clkEn, .lcdSegEnH,
    .lcdSegOutH, .lcdSegEnP, .lcdSegOutP, .spiDrive, .spiIn, .sciEnH,
    .sciEnM, .sciTxOut, .sciRxIn, .busClkOutEn, .busClkDiv, .timer1Drive,
    .timer0Drive, .timer1In, .timer0In, .pwmDrive, .pwmIn, .gpioH,
    .gpioM, .gpioP, .gpioInH, .gpioInM, .gpioInP, .portHPinsIn,
    .portMPinsIn, .portPPinsIn, .portHPinsOut, .portHPinsOe, .portMPinsOut,
    .portMPinsOe, .portPPinsOut, .portPPinsOe, .srcH, .srcM, .srcP);
  pad_model #(.W(8)) padH (.mclk, .oe(portHPinsOe), .out(portHPinsOut),
    .pinIn(portHPinsIn));
  pad_model #(.W(4)) padM (.mclk, .oe(portMPinsOe), .out(portMPinsOut),
    .pinIn(portMPinsIn));
  pad_model #(.W(8)) padP (.mclk, .oe(portPPinsOe), .out(portPPinsOut),
    .pinIn(portPPinsIn));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chks(input pin_src_e got, input pin_src_e exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask
  // GPIO pattern: pins alternate high and low, all driving
  task automatic idle();
    {clkEn, sciEnH, sciEnM, sciTxOut, busClkOutEn} = 5'b10010;
    {lcdSegEnH, lcdSegEnP, lcdSegOutH, lcdSegOutP} = 32'h00005a3c;
    busClkDiv = 8'h01;
    {spiDrive, timer1Drive, timer0Drive, pwmDrive} = '0;
    {gpioH, gpioM, gpioP} = 40'hdddd_dd_dddd;
  endtask
  task automatic t_gpio();
    idle();
    tick();
    chk(portHPinsOut, 8'haa);
    chk({portPPinsOut[7:4], portMPinsOut}, 8'haa);
    chk(gpioInH, 8'haa);
    chk(gpioInP, 8'haa);
    chk({4'h0, gpioInM}, 8'h0a);
    chk(portPPinsOe, 8'hff);
    chks(srcP[5], SRC_GPIO);
    $display("gpio test done");
  endtask
  task automatic t_h();
    idle();
    {lcdSegEnH, sciEnH} = 9'h1ff;
    spiDrive = {4{3'b101}};
    tick();
    chk(portHPinsOut, 8'h5a);
    chks(srcH[3], SRC_LCD);
    lcdSegEnH = 8'h00;
    tick();
    chk(portHPinsOut & 8'hfe, 8'ha2);
    chk(portHPinsOe, 8'hfe);
    chks(srcH[3], SRC_SPI);
    chks(srcH[1], SRC_SCI);
    chk({7'h0, sciRxIn}, {7'h0, portHPinsIn[0]});
    sciEnH = 1'b0;
    spiDrive = {4{3'b111}};
    tick();
    chks(srcH[1], SRC_SPI);
    chks(srcH[0], SRC_SPI);
    chk({4'h0, portHPinsOut[3:0]}, 8'h0f);
    chk({4'h0, spiIn}, 8'h0f);
    chk({7'h0, sciRxIn}, 8'h00);
    $display("port h test done");
  endtask
  task automatic t_clk();
    idle();
    busClkOutEn = 1'b1;
    spiDrive[2] = 3'b101;
    tick();
    chks(srcH[2], SRC_SPI);
    spiDrive = '0;
    tick();
    chks(srcH[2], SRC_CLK);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      prev = portHPinsOut[2];
      repeat (16) begin
        tick();
        n += int'(portHPinsOut[2] !== prev);
        prev = portHPinsOut[2];
      end
      chk(n[7:0], k ? 8'h00 : 8'h08);
      clkEn = 1'b0;
    end
    $display("clock test done");
  endtask
  task automatic t_m();
    idle();
    pwmDrive = {8{3'b111}};
    tick();
    chk({4'h0, portMPinsOut}, 8'h0f);
    chks(srcM[1], SRC_PWM);
    chk(pwmIn, 8'hff);
    timer1Drive = {2{3'b101}};
    timer0Drive = {2{3'b101}};
    tick();
    chk({4'h0, portMPinsOut}, 8'h00);
    chks(srcM[2], SRC_TIMER);
    chks(srcM[0], SRC_TIMER);
    sciEnM = 1'b1;
    tick();
    chk({portMPinsOe, portMPinsOut & 4'he}, 8'he2);
    chks(srcM[0], SRC_SCI);
    timer1Drive = {2{3'b111}};
    timer0Drive = {2{3'b111}};
    tick();
    chk({4'h0, timer1In, timer0In}, 8'h0c);
    $display("port m test done");
  endtask
  task automatic t_p();
    idle();
    pwmDrive = {8{3'b101}};
    lcdSegEnP = 8'hf0;
    tick();
    chk(portPPinsOut, 8'h30);
    chk(portPPinsOe, 8'hff);
    chks(srcP[7], SRC_LCD);
    chks(srcP[0], SRC_PWM);
    $display("port p test done");
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    idle();
    repeat (20) tick();
    rst_b = 1'b1;
    t_gpio();
    t_h();
    t_clk();
    t_m();
    t_p();
    final_report();
  end
  // About 63 cycles are needed; over thirty times that means a hang
  initial begin
    #50us;
    err_total++;
    final_report();
  end
endmodule
bind port_hmp_pin_function_mux hmp_mux_asserts #(.DIV_W(DIV_W)) chk_i (
  .mclk, .rst_b, .clkEn, .lcdSegEnH, .lcdSegOutH, .spiDrive, .sciEnH,
  .sciEnM, .sciTxOut, .busClkOutEn, .busClkDiv, .timer1Drive, .timer0Drive,
  .pwmDrive, .portHPinsOut, .portHPinsOe, .portMPinsOut);

// *** include/hmp_mux_pkg.sv ***
// Shared types and constants for the port H/M/P pin function multiplexer
package hmp_mux_pkg;

  localparam int PORT_H_WIDTH = 8;
  localparam int PORT_M_WIDTH = 4;
  localparam int PORT_P_WIDTH = 8;
  localparam int DIV_WIDTH = 8;

  // Segment index of the first frontplane line on each port
  localparam int SEG_H_BASE = 19;
  localparam int SEG_P_BASE = 0;

  // Pin positions of shared functions
  localparam int PH_SS = 3;
  localparam int PH_SCK = 2;
  localparam int PH_MOSI = 1;
  localparam int PH_MISO = 0;
  localparam int PM_TXD = 1;
  localparam int PM_RXD = 0;
  localparam int PM_T1_LO = 2;
  localparam int PM_T1_HI = 3;
  localparam int PM_PWM_BASE = 4;
  localparam int T0_CH_TX = 3;
  localparam int T0_CH_RX = 2;

  localparam logic [DIV_WIDTH-1:0] DIV_RESET = 8'h00;

  // Selected source of one pin
  typedef enum logic [2:0] {
    SRC_GPIO = 3'b000,
    SRC_LCD = 3'b001,
    SRC_SPI = 3'b010,
    SRC_SCI = 3'b011,
    SRC_TIMER = 3'b100,
    SRC_PWM = 3'b101,
    SRC_CLK = 3'b110
  } pin_src_e;

  // Drive of one peripheral onto a pin
  typedef struct packed {
    logic en;
    logic out;
    logic oe;
  } pin_drive_s;

  // Pin-side signals of one pin
  typedef struct packed {
    logic out;
    logic oe;
  } pad_s;

endpackage
